// ### hw/alic_map.svh
`ifndef ALIC_MAP_SVH
`define ALIC_MAP_SVH

// ----------------------------------------------------------------
// Log geometry and counter limits
// ----------------------------------------------------------------
`define ALIC_LOG_DEPTH      5'd30
`define ALIC_LOG_LAST       5'd29
`define ALIC_CNT_MAX        6'h3f

// ----------------------------------------------------------------
// Description code ranges that decide the category
// ----------------------------------------------------------------
`define ALIC_INPUT_BASE     8'h40
`define ALIC_LIMIT_BASE     8'h80

// ----------------------------------------------------------------
// Description codes of the documented causes
// ----------------------------------------------------------------
`define ALIC_DESC_POWER_FAIL 8'h01
`define ALIC_DESC_BATT_LOW   8'h02
`define ALIC_DESC_WATCHDOG   8'h03
`define ALIC_DESC_RAM_CSUM   8'h04
`define ALIC_DESC_ROM_CSUM   8'h05
`define ALIC_DESC_AIN_FAIL   8'h41
`define ALIC_DESC_DENS_FAIL  8'h42
`define ALIC_DESC_BAD_DATA   8'h43
`define ALIC_DESC_USER_LIMIT 8'h81
`define ALIC_DESC_SYS_LIMIT  8'h82

// ----------------------------------------------------------------
// Qualifier letters (ASCII)
// ----------------------------------------------------------------
`define ALIC_QUAL_HIGH      8'h48
`define ALIC_QUAL_LOW       8'h4c
`define ALIC_QUAL_STEP      8'h53

// ----------------------------------------------------------------
// Flash timing
// ----------------------------------------------------------------
`define ALIC_CLK_MHZ        10
`define ALIC_BLINK_HALF_US  500000
`define ALIC_BLINK_HALF_CYC (`ALIC_BLINK_HALF_US * `ALIC_CLK_MHZ)
`define ALIC_BLINK_CNT_W    23

`endif

// ### hw/alic_pkg.sv
package alic_pkg;

	// ----------------------------------------------------------------
	// Alarm categories, qualifier kinds and indicator states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ALIC_CAT_SYS = 2'b00,
		ALIC_CAT_INP = 2'b01,
		ALIC_CAT_LIM = 2'b10
	} alic_cat_t;

	typedef enum logic [1:0] {
		ALIC_QUAL_NONE   = 2'b00,
		ALIC_QUAL_CHAN   = 2'b01,
		ALIC_QUAL_LETTER = 2'b10
	} alic_qual_t;

	typedef enum logic [1:0] {
		ALIC_LED_OFF    = 2'b00,
		ALIC_LED_FLASH  = 2'b01,
		ALIC_LED_STEADY = 2'b10
	} alic_led_t;

	// ----------------------------------------------------------------
	// One log entry; stamp is BCD DD MM YY HH MM SS, day in the top byte
	// ----------------------------------------------------------------
	typedef struct packed {
		alic_cat_t   cat;
		logic        isOn;
		logic [7:0]  desc;
		alic_qual_t  qualKind;
		logic [7:0]  qual;
		logic [47:0] stamp;
		logic        unacc;
	} alic_entry_t;

endpackage : alic_pkg

// ### hw/alic_blink.sv
`timescale 1ns/1ps
`include "alic_map.svh"

module alic_blink #(
	parameter int HALF_CYC = `ALIC_BLINK_HALF_CYC
) (
	// Clock and control
	input  wire logic core_clk,
	input  wire logic srst,
	input  wire logic ce,
	// Square wave for flashing indicators
	output logic      blink
);

	logic [`ALIC_BLINK_CNT_W-1:0] cnt_r;
	logic [`ALIC_BLINK_CNT_W-1:0] cnt_nxt;
	logic                         blink_r;
	logic                         blink_nxt;

	// ----------------------------------------------------------------
	// Prescaler
	// ----------------------------------------------------------------

	// Free running so all flashing indicators stay in phase
	always_comb
	begin
		cnt_nxt   = cnt_r + 1'b1;
		blink_nxt = blink_r;
		if (cnt_r == `ALIC_BLINK_CNT_W'(HALF_CYC - 1)) // RULE21
		begin
			cnt_nxt   = '0;
			blink_nxt = ~blink_r;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			cnt_r   <= '0;
			blink_r <= 1'b0;
		end
		else if (ce)
		begin
			cnt_r   <= cnt_nxt;
			blink_r <= blink_nxt;
		end
	end

	assign blink = blink_r;

endmodule : alic_blink

// ### hw/alarm_log_indicator_controller.sv
// Overview of operation
// RULE1: Sort alarms into three categories, one indicator each
// RULE2: Indicator off, flashing if unaccepted, steady if accepted
// RULE3: New alarm makes its indicator flash
// RULE4: Log holds at most 30 entries
// RULE5: Append new entry while log has room
// RULE6: Full log: overwrite oldest or drop, per setting
// RULE7: Counts always updated on arrival
// RULE8: Keep new and live count per category
// RULE9: Alarm counts as new until accepted
// RULE10: Fault is live between ON and OFF
// RULE11: Each condition logs ON and OFF events
// RULE12: Entry holds category, ON/OFF, code, qualifier, stamp, flag
// RULE13: Qualifier is channel digit or letter H/L/S
// RULE14: Entry stamped on arrival with date and time
// RULE15: Accept clears the viewed entry's unaccepted flag
// RULE16: Clear removes the single viewed entry
// RULE17: Flag earlier and later entries while browsing
// RULE18: Clear all empties log, counts, indicators
// RULE19: System causes: power, battery, watchdog, checksums
// RULE20: Input causes and limit causes map to categories
// RULE21: Flashing toggles at prescaled rate
// RULE22: Accept and single clear keep counts consistent
`timescale 1ns/1ps
`include "alic_map.svh"

module alarm_log_indicator_controller #(
	parameter int BLINK_HALF_CYC = `ALIC_BLINK_HALF_CYC
) (
	// Clock and control
	input  wire logic                 core_clk,
	input  wire logic                 srst,
	input  wire logic                 ce,
	// Alarm source
	input  wire logic                 alarmValid,
	input  wire logic                 alarmOn,
	input  wire logic [7:0]           alarmDesc,
	input  wire alic_pkg::alic_qual_t alarmQualKind,
	input  wire logic [7:0]           alarmQual,
	input  wire logic [47:0]          timeNow,
	// Configuration
	input  wire logic                 fullOverwrite,
	// Operator commands, one-cycle pulses
	input  wire logic                 viewEarlier,
	input  wire logic                 viewLater,
	input  wire logic                 acceptOne,
	input  wire logic                 clearOne,
	input  wire logic                 clearAll,
	// Indicators
	output logic                      ledSystem,
	output logic                      ledInput,
	output logic                      ledLimit,
	// Summary counts
	output logic [5:0]                newSystem,
	output logic [5:0]                newInput,
	output logic [5:0]                newLimit,
	output logic [5:0]                liveSystem,
	output logic [5:0]                liveInput,
	output logic [5:0]                liveLimit,
	// Log status and viewed entry
	output logic [4:0]                logCount,
	output logic                      logFull,
	output logic [4:0]                viewIndex,
	output logic                      hasEarlier,
	output logic                      hasLater,
	output alic_pkg::alic_cat_t       viewCat,
	output logic                      viewIsOn,
	output logic [7:0]                viewDesc,
	output alic_pkg::alic_qual_t      viewQualKind,
	output logic [7:0]                viewQual,
	output logic [47:0]               viewStamp,
	output logic                      viewUnaccepted
);
	import alic_pkg::*;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Code ranges decide the category of every alarm
	function automatic alic_cat_t catOf(input logic [7:0] desc);
		if (desc < `ALIC_INPUT_BASE)
			return ALIC_CAT_SYS; // RULE19
		else if (desc < `ALIC_LIMIT_BASE)
			return ALIC_CAT_INP; // RULE20
		else
			return ALIC_CAT_LIM; // RULE20
	endfunction : catOf

	// Counters saturate rather than wrap so a flood never reads as zero
	function automatic logic [5:0] satInc(input logic [5:0] v);
		return (v == `ALIC_CNT_MAX) ? v : v + 6'h01;
	endfunction : satInc

	function automatic logic [5:0] satDec(input logic [5:0] v);
		return (v == 6'h00) ? v : v - 6'h01;
	endfunction : satDec

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	alic_entry_t ent_r     [30];
	alic_entry_t ent_nxt   [30];
	logic [4:0]  count_r;
	logic [4:0]  count_nxt;
	logic [4:0]  view_r;
	logic [4:0]  view_nxt;
	logic [5:0]  newCnt_r  [3];
	logic [5:0]  newCnt_nxt[3];
	logic [5:0]  liveCnt_r [3];
	logic [5:0]  liveCnt_nxt[3];
	alic_led_t   led_r     [3];
	alic_led_t   led_nxt   [3];
	logic [2:0]  ledOut_r;
	logic [2:0]  ledOut_nxt;
	logic        earlier_r;
	logic        earlier_nxt;
	logic        later_r;
	logic        later_nxt;
	logic        full_r;
	logic        full_nxt;
	alic_entry_t viewEnt_r;
	alic_entry_t viewEnt_nxt;
	logic        blink;
	alic_cat_t   catIn;
	alic_entry_t newEnt;
	logic [5:0]  newSel;

	alic_blink #(
		.HALF_CYC (BLINK_HALF_CYC)
	) u_blink (
		.core_clk (core_clk),
		.srst     (srst),
		.ce       (ce),
		.blink    (blink)
	);

	// Incoming alarm as it would be logged
	always_comb
	begin
		catIn           = catOf(alarmDesc); // RULE1
		newEnt.cat      = catIn; // RULE12
		newEnt.isOn     = alarmOn; // RULE11
		newEnt.desc     = alarmDesc;
		newEnt.qualKind = alarmQualKind; // RULE13
		newEnt.qual     = (alarmQualKind == ALIC_QUAL_NONE) ? 8'h00 : alarmQual;
		newEnt.stamp    = timeNow; // RULE14
		newEnt.unacc    = 1'b1;
	end

	assign newSel = newCnt_r[catIn];

	// ----------------------------------------------------------------
	// Log, counts and indicators
	// ----------------------------------------------------------------

	// One operation per cycle: clear all, arrival, clear one, accept, browse
	always_comb
	begin
		logic [2:0]  present;
		alic_entry_t gone;
		present     = 3'b000;
		gone        = ent_r[view_r];
		ent_nxt     = ent_r;
		count_nxt   = count_r;
		view_nxt    = view_r;
		newCnt_nxt  = newCnt_r;
		liveCnt_nxt = liveCnt_r;
		led_nxt     = led_r;
		if (clearAll)
		begin
			for (int i = 0; i < 30; i++)
				ent_nxt[i] = '0; // RULE18
			count_nxt = 5'd0;
			view_nxt  = 5'd0;
			for (int c = 0; c < 3; c++)
			begin
				newCnt_nxt[c]  = 6'h00;
				liveCnt_nxt[c] = 6'h00;
				led_nxt[c]     = ALIC_LED_OFF;
			end
		end
		else if (alarmValid)
		begin
			// Insert at the top; when full the bottom (oldest) falls off
			if (count_r < `ALIC_LOG_DEPTH || fullOverwrite) // RULE5 RULE6
			begin
				for (int i = 29; i > 0; i--)
					ent_nxt[i] = ent_r[i-1];
				ent_nxt[0] = newEnt;
				if (count_r < `ALIC_LOG_DEPTH) // RULE4
					count_nxt = count_r + 5'd1;
				// Keep the operator on the entry being viewed
				if (count_r != 5'd0 && view_r < count_nxt - 5'd1)
					view_nxt = view_r + 5'd1;
			end
			newCnt_nxt[catIn] = satInc(newCnt_r[catIn]); // RULE7 RULE8 RULE9
			if (alarmOn)
				liveCnt_nxt[catIn] = satInc(liveCnt_r[catIn]); // RULE10
			else
				liveCnt_nxt[catIn] = satDec(liveCnt_r[catIn]); // RULE10
			led_nxt[catIn] = ALIC_LED_FLASH; // RULE3
		end
		else if (clearOne && count_r != 5'd0)
		begin
			for (int i = 0; i < 29; i++)
				if (5'(i) >= view_r)
					ent_nxt[i] = ent_r[i+1]; // RULE16
			ent_nxt[29] = '0;
			count_nxt   = count_r - 5'd1;
			if (gone.unacc)
				newCnt_nxt[gone.cat] = satDec(newCnt_r[gone.cat]); // RULE22
			if (view_r == count_r - 5'd1 && view_r != 5'd0)
				view_nxt = view_r - 5'd1;
		end
		else if (acceptOne && count_r != 5'd0 && gone.unacc)
		begin
			ent_nxt[view_r].unacc = 1'b0; // RULE15
			newCnt_nxt[gone.cat] = satDec(newCnt_r[gone.cat]); // RULE22 RULE9
		end
		else if (viewEarlier && view_r != 5'd0)
			view_nxt = view_r - 5'd1;
		else if (viewLater && view_r + 5'd1 < count_r)
			view_nxt = view_r + 5'd1;
		// Categories that still have entries in the log
		for (int i = 0; i < 30; i++)
			if (5'(i) < count_nxt)
				present[ent_nxt[i].cat] = 1'b1;
		for (int c = 0; c < 3; c++)
		begin
			// All accepted turns flashing to steady; nothing left turns it off
			if (led_nxt[c] == ALIC_LED_FLASH && newCnt_nxt[c] == 6'h00)
				led_nxt[c] = ALIC_LED_STEADY; // RULE2
			if (!present[c] && newCnt_nxt[c] == 6'h00 && liveCnt_nxt[c] == 6'h00)
				led_nxt[c] = ALIC_LED_OFF; // RULE2
			ledOut_nxt[c] = (led_nxt[c] == ALIC_LED_FLASH) ? blink :
			                (led_nxt[c] == ALIC_LED_STEADY); // RULE21
		end
		earlier_nxt = (count_nxt != 5'd0) && (view_nxt != 5'd0); // RULE17
		later_nxt   = ({1'b0, view_nxt} + 6'h01) < {1'b0, count_nxt}; // RULE17
		full_nxt    = (count_nxt == `ALIC_LOG_DEPTH);
		viewEnt_nxt = (count_nxt == 5'd0) ? '0 : ent_nxt[view_nxt];
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			for (int i = 0; i < 30; i++)
				ent_r[i] <= '0;
			for (int c = 0; c < 3; c++)
			begin
				newCnt_r[c]  <= 6'h00;
				liveCnt_r[c] <= 6'h00;
				led_r[c]     <= ALIC_LED_OFF;
			end
			count_r   <= 5'd0;
			view_r    <= 5'd0;
			ledOut_r  <= 3'b000;
			earlier_r <= 1'b0;
			later_r   <= 1'b0;
			full_r    <= 1'b0;
			viewEnt_r <= '0;
		end
		else if (ce)
		begin
			ent_r     <= ent_nxt;
			newCnt_r  <= newCnt_nxt;
			liveCnt_r <= liveCnt_nxt;
			led_r     <= led_nxt;
			count_r   <= count_nxt;
			view_r    <= view_nxt;
			ledOut_r  <= ledOut_nxt;
			earlier_r <= earlier_nxt;
			later_r   <= later_nxt;
			full_r    <= full_nxt;
			viewEnt_r <= viewEnt_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign ledSystem      = ledOut_r[0]; // RULE1
	assign ledInput       = ledOut_r[1];
	assign ledLimit       = ledOut_r[2];
	assign newSystem      = newCnt_r[0];
	assign newInput       = newCnt_r[1];
	assign newLimit       = newCnt_r[2];
	assign liveSystem     = liveCnt_r[0];
	assign liveInput      = liveCnt_r[1];
	assign liveLimit      = liveCnt_r[2];
	assign logCount       = count_r;
	assign logFull        = full_r;
	assign viewIndex      = view_r;
	assign hasEarlier     = earlier_r;
	assign hasLater       = later_r;
	assign viewCat        = viewEnt_r.cat;
	assign viewIsOn       = viewEnt_r.isOn;
	assign viewDesc       = viewEnt_r.desc;
	assign viewQualKind   = viewEnt_r.qualKind;
	assign viewQual       = viewEnt_r.qual;
	assign viewStamp      = viewEnt_r.stamp;
	assign viewUnaccepted = viewEnt_r.unacc;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	a_log_bound: assert property (count_r <= `ALIC_LOG_DEPTH) // RULE4
		else $error("log count above depth");
	a_append_grow: assert property (ce && !clearAll && alarmValid && count_r < 5'd30 // RULE5
		|=> count_r == $past(count_r) + 5'd1 && ent_r[0].stamp == $past(timeNow))
		else $error("append did not grow log");
	a_full_drop: assert property (ce && !clearAll && alarmValid && count_r == 5'd30 // RULE6
		&& !fullOverwrite |=> count_r == 5'd30 && $stable(ent_r[0]))
		else $error("full log did not drop alarm");
	a_new_count: assert property (ce && !clearAll && alarmValid && newSel != 6'h3f // RULE7
		|=> newCnt_r[$past(catIn)] == $past(newSel) + 6'h01)
		else $error("new count not raised");
	a_flash_new: assert property (ce && !clearAll && alarmValid // RULE3
		|=> led_r[$past(catIn)] == ALIC_LED_FLASH)
		else $error("indicator not flashing after alarm");
	a_steady_ok: assert property (led_r[0] == ALIC_LED_STEADY |-> newCnt_r[0] == 6'h00) // RULE2
		else $error("steady with unaccepted alarms");
	a_accept_flag: assert property (ce && !clearAll && !alarmValid && !clearOne && acceptOne // RULE15
		&& count_r != 5'd0 && ent_r[view_r].unacc |=> !ent_r[$past(view_r)].unacc)
		else $error("accept left flag set");
	a_clear_one: assert property (ce && !clearAll && !alarmValid && clearOne // RULE16
		&& count_r != 5'd0 |=> count_r == $past(count_r) - 5'd1)
		else $error("single clear did not shrink log");
	a_clear_all: assert property (ce && clearAll |=> count_r == 5'd0 // RULE18
		&& ledOut_r == 3'b000 && newCnt_r[1] == 6'h00 && liveCnt_r[2] == 6'h00)
		else $error("clear all incomplete");
	a_view_flags: assert property (earlier_r == (count_r != 5'd0 && view_r != 5'd0)) // RULE17
		else $error("earlier flag wrong");
	a_view_range: assert property (count_r == 5'd0 || view_r < count_r) // RULE17
		else $error("view outside log");

endmodule : alarm_log_indicator_controller

// ### test/alic_source_model.sv
`timescale 1ns/1ps

module alic_source_model (
	// Clock
	input  wire logic                 core_clk,
	// Alarm event lines toward the controller
	output logic                      alarmValid,
	output logic                      alarmOn,
	output logic [7:0]                alarmDesc,
	output alic_pkg::alic_qual_t      alarmQualKind,
	output logic [7:0]                alarmQual,
	// External time of day, BCD
	output logic [47:0]               timeNow
);
	import alic_pkg::*;

	// ----------------------------------------------------------------
	// Idle lines
	// ----------------------------------------------------------------
	// Between events the on, code and qualifier lines carry inverted junk; qualifier kind and time keep the last value
	initial
	begin
		alarmValid = 1'b0;
		alarmOn = 1'b0;
		alarmDesc = 8'h00;
		alarmQualKind = ALIC_QUAL_NONE;
		alarmQual = 8'h00;
		timeNow = 48'h010100000000;
	end

	// ----------------------------------------------------------------
	// One event, held for one taking edge
	// ----------------------------------------------------------------
	task automatic raise(input logic on, input logic [7:0] d, input alic_qual_t k,
		input logic [7:0] q, input logic [47:0] st);
		@(posedge core_clk);
		#1;
		alarmValid = 1'b1;
		alarmOn = on;
		alarmDesc = d;
		alarmQualKind = k;
		alarmQual = q;
		timeNow = st;
		@(posedge core_clk);
		#1;
		alarmValid = 1'b0;
		alarmOn = ~on;
		alarmDesc = ~d;
		alarmQual = ~q;
	endtask : raise

endmodule : alic_source_model

// ### test/tb_alarm_log_indicator_controller.sv
`timescale 1ns/1ps
`include "alic_map.svh"

module tb_alarm_log_indicator_controller;
	import alic_pkg::*;

	// ----------------------------------------------------------------
	// Wiring
	// ----------------------------------------------------------------
	localparam int HALF = 4; // Short blink keeps the run brief
	// Keypad codes in the order {earlier, later, accept, clear one, clear all}
	localparam logic [4:0] keyEarlier = 5'h10;
	localparam logic [4:0] keyLater   = 5'h08;
	localparam logic [4:0] keyAccept  = 5'h04;
	localparam logic [4:0] keyClrOne  = 5'h02;
	localparam logic [4:0] keyClrAll  = 5'h01;
	logic        core_clk, srst, ce, fullOverwrite;
	logic        viewEarlier, viewLater, acceptOne, clearOne, clearAll;
	logic        alarmValid, alarmOn, ledSystem, ledInput, ledLimit;
	logic [7:0]  alarmDesc, alarmQual, viewDesc, viewQual;
	alic_qual_t  alarmQualKind, viewQualKind;
	alic_cat_t   viewCat;
	logic [47:0] timeNow, viewStamp, st, prevTop;
	logic [5:0]  newSystem, newInput, newLimit, liveSystem, liveInput, liveLimit;
	logic [4:0]  logCount, viewIndex;
	logic        logFull, hasEarlier, hasLater, viewIsOn, viewUnaccepted;
	int          mismatches, n_checks, nEv, expCount;
	int          expNew [3];
	int          expLive [3];

	alic_source_model src (.core_clk(core_clk), .alarmValid(alarmValid), .alarmOn(alarmOn),
		.alarmDesc(alarmDesc), .alarmQualKind(alarmQualKind), .alarmQual(alarmQual),
		.timeNow(timeNow));

	alarm_log_indicator_controller #(.BLINK_HALF_CYC(HALF)) dut (.core_clk(core_clk),
		.srst(srst), .ce(ce), .alarmValid(alarmValid), .alarmOn(alarmOn),
		.alarmDesc(alarmDesc), .alarmQualKind(alarmQualKind), .alarmQual(alarmQual),
		.timeNow(timeNow), .fullOverwrite(fullOverwrite), .viewEarlier(viewEarlier),
		.viewLater(viewLater), .acceptOne(acceptOne), .clearOne(clearOne),
		.clearAll(clearAll), .ledSystem(ledSystem), .ledInput(ledInput),
		.ledLimit(ledLimit), .newSystem(newSystem), .newInput(newInput),
		.newLimit(newLimit), .liveSystem(liveSystem), .liveInput(liveInput),
		.liveLimit(liveLimit), .logCount(logCount), .logFull(logFull),
		.viewIndex(viewIndex), .hasEarlier(hasEarlier), .hasLater(hasLater),
		.viewCat(viewCat), .viewIsOn(viewIsOn), .viewDesc(viewDesc),
		.viewQualKind(viewQualKind), .viewQual(viewQual), .viewStamp(viewStamp),
		.viewUnaccepted(viewUnaccepted));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Clock of 100 ns period
	initial
	begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test

	// Keypad: one-cycle pulse, outputs settled on return
	task automatic press(input logic [4:0] key);
		@(posedge core_clk);
		#1;
		{viewEarlier, viewLater, acceptOne, clearOne, clearAll} = key;
		@(posedge core_clk);
		#1;
		{viewEarlier, viewLater, acceptOne, clearOne, clearAll} = 5'h00;
	endtask : press

	task automatic cnts;
		chk(newSystem, expNew[0]);
		chk(newInput, expNew[1]);
		chk(newLimit, expNew[2]);
		chk(liveSystem, expLive[0]);
		chk(liveInput, expLive[1]);
		chk(liveLimit, expLive[2]);
		chk(logCount, expCount);
	endtask : cnts

	// Browse to the newest entry under a bounded count
	task automatic top;
		for (int i = 0; i < 31 && viewIndex !== 5'h00; i++)
			press(keyEarlier);
		chk(viewIndex, 0);
		if (viewIndex !== 5'h00)
			end_of_test();
	endtask : top

	// Indicator mode over two blink periods: 0 off, 1 steady, 2 flashing
	task automatic led(input int c, input int m);
		int hi;
		hi = 0;
		repeat (4 * HALF)
		begin
			@(posedge core_clk);
			#1;
			hi += (c == 0) ? ledSystem : ((c == 1) ? ledInput : ledLimit);
		end
		chk((m == 0 && hi == 0) || (m == 1 && hi == 4 * HALF) ||
			(m == 2 && hi > 0 && hi < 4 * HALF), 1);
	endtask : led

	// One alarm event with the expected bookkeeping
	task automatic ev(input logic on, input logic [7:0] d, input alic_qual_t k,
		input logic [7:0] q);
		int c;
		logic lg;
		c = (d < `ALIC_INPUT_BASE) ? 0 : ((d < `ALIC_LIMIT_BASE) ? 1 : 2);
		lg = (expCount < 30) || fullOverwrite;
		nEv++;
		st = {40'h1506241020, 4'(nEv / 10), 4'(nEv % 10)};
		src.raise(on, d, k, q, st);
		expNew[c]++;
		if (on)
			expLive[c]++;
		else if (expLive[c] > 0)
			expLive[c]--;
		if (expCount < 30)
			expCount++;
		top();
		cnts();
		if (lg)
		begin
			prevTop = st;
			chk(viewCat, c);
			chk(viewIsOn, on);
			chk(viewDesc, d);
			chk(viewQualKind, k);
			chk(viewQual, (k == ALIC_QUAL_NONE) ? 8'h00 : q);
			chk(viewUnaccepted, 1);
		end
		chk(viewStamp, prevTop);
	endtask : ev

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	localparam logic [7:0] CODES [10] = '{`ALIC_DESC_POWER_FAIL, `ALIC_DESC_BATT_LOW,
		`ALIC_DESC_WATCHDOG, `ALIC_DESC_RAM_CSUM, `ALIC_DESC_ROM_CSUM,
		`ALIC_DESC_AIN_FAIL, `ALIC_DESC_DENS_FAIL, `ALIC_DESC_BAD_DATA,
		`ALIC_DESC_USER_LIMIT, `ALIC_DESC_SYS_LIMIT};

	initial
	begin
		{srst, ce, fullOverwrite} = 3'b110;
		{viewEarlier, viewLater, acceptOne, clearOne, clearAll} = 5'h00;
		mismatches = 0;
		n_checks = 0;
		nEv = 0;
		expCount = 0;
		expNew = '{0, 0, 0};
		expLive = '{0, 0, 0};
		prevTop = 48'h0;
		repeat (3) @(posedge core_clk);
		#1;
		srst = 1'b0;
		cnts();
		led(0, 0);
		$display("test reset done");
		// Every documented cause, with each qualifier kind
		for (int i = 0; i < 10; i++)
			ev(1'b1, CODES[i], (i < 5) ? ALIC_QUAL_NONE : ((i < 8) ? ALIC_QUAL_CHAN
				: ALIC_QUAL_LETTER), (i < 5) ? 8'h33 : ((i < 8) ? 8'(i - 4)
				: ((i == 8) ? `ALIC_QUAL_HIGH : `ALIC_QUAL_LOW)));
		led(0, 2);
		led(1, 2);
		led(2, 2);
		$display("test causes done");
		// Accept, refused accept, browsing to both ends
		press(keyAccept);
		expNew[2]--;
		chk(viewUnaccepted, 0);
		chk({hasEarlier, hasLater}, 2'b01);
		press(keyLater);
		chk({viewIndex, hasEarlier}, {5'h01, 1'b1});
		press(keyAccept);
		expNew[2]--;
		press(keyAccept);
		cnts();
		led(2, 1);
		for (int i = 0; i < 10 && viewIndex !== 5'h09; i++)
			press(keyLater);
		press(keyLater);
		chk({viewIndex, hasLater}, {5'h09, 1'b0});
		$display("test accept done");
		// Steady turns back to flashing; OFF event ends a live fault
		ev(1'b1, `ALIC_DESC_USER_LIMIT, ALIC_QUAL_LETTER, `ALIC_QUAL_STEP);
		led(2, 2);
		ev(1'b0, `ALIC_DESC_POWER_FAIL, ALIC_QUAL_NONE, 8'h00);
		press(keyClrOne);
		expNew[0]--;
		expCount--;
		cnts();
		chk({viewDesc, viewQual}, {`ALIC_DESC_USER_LIMIT, `ALIC_QUAL_STEP});
		$display("test clear one done");
		// Full log: drop first, then overwrite the oldest
		while (expCount < 30)
			ev(1'b1, `ALIC_DESC_BAD_DATA, ALIC_QUAL_CHAN, 8'h05);
		ev(1'b1, `ALIC_DESC_RAM_CSUM, ALIC_QUAL_NONE, 8'h00);
		chk(logFull, 1);
		fullOverwrite = 1'b1;
		ev(1'b1, `ALIC_DESC_WATCHDOG, ALIC_QUAL_NONE, 8'h00);
		for (int i = 0; i < 30 && viewIndex !== 5'h1d; i++)
			press(keyLater);
		chk({viewIndex, viewDesc}, {5'h1d, `ALIC_DESC_BATT_LOW});
		$display("test full log done");
		// Clear everything
		press(keyClrAll);
		expNew = '{0, 0, 0};
		expLive = '{0, 0, 0};
		expCount = 0;
		cnts();
		chk({viewIndex, hasEarlier, hasLater, logFull}, 0);
		for (int c = 0; c < 3; c++)
			led(c, 0);
		$display("test clear all done");
		// Clock enable low: an alarm must leave the system counts, the system indicator and the log count alone
		ce = 1'b0;
		src.raise(1'b1, `ALIC_DESC_WATCHDOG, ALIC_QUAL_NONE, 8'h00, 48'h0);
		chk({logCount, newSystem, liveSystem, ledSystem}, 0);
		ce = 1'b1;
		$display("test clock enable done");
		end_of_test();
	end

endmodule : tb_alarm_log_indicator_controller
